// ### sereep_fifo.sv
// Shared constants for the serial EEPROM read path, and the load-path FIFO.
// Assumes one clock domain, ref_clk, with asynchronous active-low reset nrst.
package sereep_pkg;
    localparam int WORD_W = 16;
    localparam int DEF_ADDR_W = 8;
    localparam int DEF_DEPTH = 256;
    localparam int OPC_W = 2;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // One-hot states of the serial command decoder.
    typedef enum logic [4:0] {
        SE_IDLE = 5'h01,
        SE_OPC = 5'h02,
        SE_ADDR = 5'h04,
        SE_STREAM = 5'h08,
        SE_SKIP = 5'h10
    } sereep_state_t;
endpackage : sereep_pkg

// Synchronous FIFO with valid/ready on both sides; inReady is registered.
module sereep_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [PTR_W:0] count_r;
    logic [PTR_W:0] count_nxt;
    logic doWrite;
    logic doRead;

    // Handshakes on each side and the resulting fill level.
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outValid = (count_r != '0);
    assign outData = store[rdPtr_r];
    assign count_nxt = count_r + (PTR_W+1)'(doWrite) - (PTR_W+1)'(doRead);

    // Pointers, level and the registered ready toward the source.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            inReady <= 1'b0;
        end else begin
            if (doWrite) begin
                wrPtr_r <= (wrPtr_r == PTR_W'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doRead) begin
                rdPtr_r <= (rdPtr_r == PTR_W'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_nxt;
            inReady <= (count_nxt != (PTR_W+1)'(DEPTH));
        end
    end

    // Storage is not reset; only written entries are ever read.
    always_ff @(posedge clk) begin
        if (doWrite) begin
            store[wrPtr_r] <= inData;
        end
    end
endmodule : sereep_fifo

// ### sereep_top.sv
// Serial EEPROM sequential-read engine as it sits behind the device pins.
// Assumes select, shift clock and data in come from another domain and
// are sampled by ref_clk at well above twice the shift-clock rate.
// Summary of operation
// RULE_01: Host sends start bit, read opcode, then first address.
// RULE_02: Host always supplies a start address; prior address is undefined.
// RULE_03: Data output stays undriven through start, opcode and early address bits.
// RULE_04: On the rise capturing address_lsb, output drives a low dummy bit.
// RULE_05: Data bits follow the dummy; later words stream with no gaps.
// RULE_06: Words keep coming for as long as the host keeps clocking.
// RULE_07: After the top address, the read address wraps to zero.
// RULE_08: Write-protect boundary never limits sequential reads.
// RULE_09: Host ends the stream only by lowering select.
// RULE_10: Select going low aborts any instruction in progress.
// RULE_11: Abort at any bit position leaves stored contents untouched.
// RULE_12: Array holds 16-bit words, 16 to 256 deep per variant.
// RULE_13: Address field is 6 or 8 bits, matching depth.
// RULE_14: Words shift out MSB first, one bit per rising shift clock.
module sereep_top
    import sereep_pkg::*;
#(
    parameter int ADDR_W = sereep_pkg::DEF_ADDR_W,
    parameter int DEPTH = sereep_pkg::DEF_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic chipSelect,
    input wire logic serialShiftClock,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutEn,
    input wire logic loadValid,
    input wire logic [ADDR_W-1:0] loadAddr,
    input wire logic [sereep_pkg::WORD_W-1:0] loadData,
    output logic loadReady
);
    import sereep_pkg::*;

    localparam logic [ADDR_W-1:0] MAX_ADDR = ADDR_W'(DEPTH-1);
    localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_W-1);
    localparam logic [CNT_W-1:0] OPC_LAST = CNT_W'(OPC_W-1);
    // Array index width; upper address bits alias when the array is smaller.
    localparam int MEM_AW = $clog2(DEPTH);

    logic [1:0] csSync_r;
    logic [1:0] skSync_r;
    logic [1:0] diSync_r;
    logic skPrev_r;
    logic csOn;
    logic din;
    logic skRise;
    sereep_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [OPC_W-1:0] opc_r;
    logic [ADDR_W-1:0] addrShift_r;
    logic [ADDR_W-1:0] readAddr_r;
    logic [ADDR_W-1:0] firstAddr;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] mem [DEPTH];
    logic fifoValid;
    logic fifoReady;
    logic [ADDR_W+WORD_W-1:0] fifoData;
    logic lastAddrRise;

    // Two-flop synchronisers for select, shift clock and data in; only the second stage is read.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            csSync_r <= SYNC_ZERO;
            skSync_r <= SYNC_ZERO;
            diSync_r <= SYNC_ZERO;
            skPrev_r <= 1'b0;
        end else begin
            csSync_r <= {csSync_r[0], chipSelect};
            skSync_r <= {skSync_r[0], serialShiftClock};
            diSync_r <= {diSync_r[0], serialDataIn};
            skPrev_r <= skSync_r[1];
        end
    end

    assign csOn = csSync_r[1];
    assign din = diSync_r[1];
    assign skRise = skSync_r[1] && !skPrev_r && csOn;
    assign firstAddr = {addrShift_r[ADDR_W-2:0], din};
    assign lastAddrRise = skRise && (state_r == SE_ADDR) && (cnt_r == ADDR_LAST);

    // Command decoder: start bit, opcode, address, then streaming.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SE_IDLE;
            cnt_r <= CNT_ZERO;
            opc_r <= '0;
            addrShift_r <= '0;
        end else if (!csOn) begin
            state_r <= SE_IDLE; // RULE_10
            cnt_r <= CNT_ZERO;
        end else if (skRise) begin
            unique case (state_r)
                SE_IDLE: begin
                    if (din) begin
                        state_r <= SE_OPC; // RULE_01
                        cnt_r <= CNT_ZERO;
                    end
                end
                SE_OPC: begin
                    opc_r <= {opc_r[OPC_W-2:0], din};
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == OPC_LAST) begin
                        cnt_r <= CNT_ZERO;
                        // Only the read opcode is served; others wait for deselect.
                        state_r <= ({opc_r[OPC_W-2:0], din} == OPC_READ) ? SE_ADDR : SE_SKIP;
                    end
                end
                SE_ADDR: begin
                    addrShift_r <= firstAddr; // RULE_02
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == ADDR_LAST) begin
                        state_r <= SE_STREAM; // RULE_13
                        cnt_r <= CNT_ZERO;
                    end
                end
                SE_STREAM: begin
                    cnt_r <= cnt_r + 1'b1; // RULE_06
                end
                SE_SKIP: begin
                    state_r <= SE_SKIP;
                end
            endcase
        end
    end

    // Output pin: undriven until the dummy low, then word bits MSB first.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serialDataOut <= 1'b0;
            serialDataOutEn <= 1'b0; // RULE_03
        end else if (!csOn) begin
            serialDataOutEn <= 1'b0; // RULE_10
            serialDataOut <= 1'b0;
        end else if (lastAddrRise) begin
            serialDataOutEn <= 1'b1; // RULE_04
            serialDataOut <= 1'b0;
        end else if (skRise && state_r == SE_STREAM) begin
            serialDataOut <= shift_r[WORD_W-1]; // RULE_14
        end
    end

    // Word shifter and auto-incrementing read address, wrapping at the top.
    // No protect boundary is consulted on this path.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= WORD_ZERO;
            readAddr_r <= '0;
        end else if (lastAddrRise) begin
            shift_r <= mem[firstAddr[MEM_AW-1:0]];
            readAddr_r <= (firstAddr == MAX_ADDR) ? '0 : firstAddr + 1'b1; // RULE_08
        end else if (skRise && state_r == SE_STREAM) begin
            if (cnt_r == LAST_BIT) begin
                shift_r <= mem[readAddr_r[MEM_AW-1:0]]; // RULE_05
                readAddr_r <= (readAddr_r == MAX_ADDR) ? '0 : readAddr_r + 1'b1; // RULE_07
            end else begin
                shift_r <= {shift_r[WORD_W-2:0], 1'b0};
            end
        end
    end

    // Array is only loaded from the FIFO while deselected; reads never write.
    assign fifoReady = !csOn; // RULE_11
    always_ff @(posedge ref_clk) begin
        if (fifoValid && fifoReady) begin
            mem[fifoData[WORD_W +: MEM_AW]] <= fifoData[WORD_W-1:0]; // RULE_12
        end
    end

    // Load path buffer; it stalls while a read is selected.
    sereep_fifo #(
        .WIDTH(ADDR_W + WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .nrst(nrst),
        .inValid(loadValid),
        .inData({loadAddr, loadData}),
        .inReady(loadReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(fifoReady)
    );

    property p_hiz_outside_stream;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r != SE_STREAM) && !lastAddrRise |=> !serialDataOutEn;
    endproperty
    a_hiz_outside_stream: assert property (p_hiz_outside_stream) // RULE_03
        else $error("Data output driven outside a read stream.");

    property p_dummy_low;
        @(posedge ref_clk) disable iff (!nrst)
        lastAddrRise |=> serialDataOutEn && !serialDataOut && (state_r == SE_STREAM);
    endproperty
    a_dummy_low: assert property (p_dummy_low) // RULE_04
        else $error("Dummy bit not driven low on last address bit.");

    property p_msb_first;
        @(posedge ref_clk) disable iff (!nrst)
        skRise && (state_r == SE_STREAM) |=> serialDataOut == $past(shift_r[WORD_W-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) // RULE_14
        else $error("Output bit is not the shifter MSB.");

    property p_no_gap;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SE_STREAM) && csOn |=> serialDataOutEn;
    endproperty
    a_no_gap: assert property (p_no_gap) // RULE_05
        else $error("Output released while streaming.");

    property p_abort;
        @(posedge ref_clk) disable iff (!nrst)
        !csOn |=> (state_r == SE_IDLE) && !serialDataOutEn;
    endproperty
    a_abort: assert property (p_abort) // RULE_10
        else $error("Deselect did not abort the instruction.");

    property p_wrap;
        @(posedge ref_clk) disable iff (!nrst)
        skRise && (state_r == SE_STREAM) && (cnt_r == LAST_BIT) && (readAddr_r == MAX_ADDR)
            |=> (readAddr_r == '0) && (state_r == SE_STREAM);
    endproperty
    a_wrap: assert property (p_wrap) // RULE_07
        else $error("Read address did not wrap to zero.");

    property p_word_advance;
        @(posedge ref_clk) disable iff (!nrst)
        skRise && (state_r == SE_STREAM) && (cnt_r == LAST_BIT) && (readAddr_r != MAX_ADDR)
            |=> readAddr_r == $past(readAddr_r) + 1'b1;
    endproperty
    a_word_advance: assert property (p_word_advance) // RULE_06
        else $error("Read address did not advance after a word.");

    property p_no_write_selected;
        @(posedge ref_clk) disable iff (!nrst)
        csOn && fifoValid |=> fifoValid && $stable(fifoData);
    endproperty
    a_no_write_selected: assert property (p_no_write_selected) // RULE_11
        else $error("Array written while a read is selected.");

    property p_cnt_range;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SE_ADDR) |-> cnt_r <= ADDR_LAST;
    endproperty
    a_cnt_range: assert property (p_cnt_range) // RULE_13
        else $error("Address bit count beyond field width.");
endmodule : sereep_top

// ### sereep_host_model.sv
// Host model: drives select, shift clock and data in, and samples data out.
// Assumes its tasks are called from one bench process; shift clock 160 ns.
module sereep_host_model
    import sereep_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    output logic chipSelect,
    output logic serialShiftClock,
    output logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 80;
    logic [1:0] seen[$];

    // The shift clock stands still and low outside frames.
    initial begin
        chipSelect = 1'b0;
        serialShiftClock = 1'b0;
        serialDataIn = 1'b0;
    end

    // Holds select without clocking, which stalls the load path.
    task automatic holdSelect(input logic v);
        chipSelect = v;
    endtask : holdSelect

    // Low phase, sample the output pair, then one rising shift edge.
    task automatic shiftBit(input logic b);
        serialDataIn = b;
        #HALF;
        seen.push_back({serialDataOutEn, serialDataOut});
        serialShiftClock = 1'b1;
        #HALF;
        serialShiftClock = 1'b0;
    endtask : shiftBit

    // One frame of nRise shift edges; data in toggles once the command is sent.
    task automatic frame(input logic [1:0] opc, input logic [ADDR_W-1:0] addr, input int nRise);
        logic [ADDR_W+2:0] cmd;
        int i;
        cmd = {1'b1, opc, addr};
        seen.delete();
        chipSelect = 1'b1;
        #(2 * HALF);
        for (i = 0; i < nRise; i++) begin
            shiftBit(i < ADDR_W + 3 ? cmd[ADDR_W + 2 - i] : ~serialDataIn);
        end
        #HALF;
        seen.push_back({serialDataOutEn, serialDataOut});
        chipSelect = 1'b0;
    endtask : frame
endmodule : sereep_host_model

// ### tb_top.sv
// Testbench for the serial read engine, 16-word variant with 6-bit addresses.
// Assumes the host model drives the link pins and the bench owns the load port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sereep_pkg::*;
    localparam int AW = 6;
    localparam int DP = 16;
    logic ref_clk, nrst, chipSelect, serialShiftClock, serialDataIn;
    logic serialDataOut, serialDataOutEn, loadValid, loadReady;
    logic [AW-1:0] loadAddr;
    logic [WORD_W-1:0] loadData;
    logic [WORD_W-1:0] mem[DP];
    logic [31:0] lfsr = 32'h2A92495B;
    int fails = 0;
    int nCompared = 0;
    int cycles = 0;

    sereep_top #(.ADDR_W(AW), .DEPTH(DP)) sereep_top_inst (.ref_clk(ref_clk), .nrst(nrst),
        .chipSelect(chipSelect), .serialShiftClock(serialShiftClock),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn), .loadValid(loadValid), .loadAddr(loadAddr),
        .loadData(loadData), .loadReady(loadReady));
    sereep_host_model #(.ADDR_W(AW)) sereep_host_model_inst (.chipSelect(chipSelect),
        .serialShiftClock(serialShiftClock), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn));

    // Clock at 50 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    // Next random value of the bench's shift register.
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRand

    // Expected {enable, data} seen after s shift edges of a read from address a.
    function automatic logic [1:0] expSample(input int s, input logic [AW-1:0] a);
        logic [WORD_W-1:0] w;
        if (s < AW + 3) return 2'b00;
        if (s == AW + 3) return 2'b10;
        w = mem[(a + (s - AW - 4) / WORD_W) % DP];
        return {1'b1, w[WORD_W - 1 - (s - AW - 4) % WORD_W]};
    endfunction : expSample

    // Compares a pair of bits and counts the result.
    task automatic checkBits(input string what, input logic [1:0] exp, input logic [1:0] got);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBits

    // Offers one word; valid stays high so that loads can run back to back.
    task automatic load(input logic [AW-1:0] a, input logic [WORD_W-1:0] d);
        loadAddr = a;
        loadData = d;
        loadValid = 1'b1;
        do @(posedge ref_clk); while (loadReady !== 1'b1);
        #1;
    endtask : load

    // Runs a frame and checks every sample; data is ignored while not driven.
    task automatic runFrame(input logic [1:0] opc, input logic [AW-1:0] a, input int nRise);
        logic [1:0] e;
        logic [1:0] g;
        int s;
        sereep_host_model_inst.frame(opc, a, nRise);
        for (s = 0; s <= nRise; s++) begin
            e = (opc == OPC_READ) ? expSample(s, a) : 2'b00;
            g = sereep_host_model_inst.seen[s];
            checkBits("dataOut", e, e[1] ? g : {g[1], 1'b0});
        end
        repeat (6) @(posedge ref_clk);
        #1 checkBits("outEnAfterDeselect", 2'b00, {1'b0, serialDataOutEn});
    endtask : runFrame

    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (fails == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Fills the FIFO under a stall, drains it, then reads, aborts and refuses.
    initial begin
        int i;
        logic [WORD_W-1:0] d;
        nrst = 1'b0;
        loadValid = 1'b0;
        loadAddr = '0;
        loadData = '0;
        repeat (4) @(posedge ref_clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 sereep_host_model_inst.holdSelect(1'b1);
        repeat (4) @(posedge ref_clk);
        #1;
        for (i = 0; i < 2 * DP; i++) begin
            lfsr = nextRand(lfsr);
            d = (i == DP) ? 16'h0000 : (i == 2 * DP - 1) ? 16'hFFFF : lfsr[15:0];
            mem[i % DP] = d;
            load(AW'(i % DP), d);
        end
        loadValid = 1'b0;
        @(posedge ref_clk);
        #1 checkBits("loadReadyFull", 2'b00, {1'b0, loadReady});
        sereep_host_model_inst.holdSelect(1'b0);
        repeat (50) @(posedge ref_clk);
        #1 checkBits("loadReadyDrained", 2'b01, {1'b0, loadReady});
        runFrame(OPC_READ, {2'b00, lfsr[3:0]}, AW + 4 + WORD_W * 20);
        runFrame(OPC_READ, 6'h0F, AW + 4 + WORD_W + 7);
        runFrame(OPC_READ, 6'h00, AW + 4 + WORD_W * 2);
        for (i = 0; i < 4; i++) begin
            if (2'(i) != OPC_READ) begin
                runFrame(2'(i), 6'h03, AW + 4 + 8);
            end
        end
        complete_run();
    end
endmodule : tb_top
